// [logic/anv_device.sv]
// Summary of operation
// - old coefficients stay until commit flag written
// - enable bit 14 of first register
// - bit 14 of second selects lowpass
// - a0 and a1 in bits 13:0, reset zero
// - coefficients are 14-bit sign/magnitude words
// - a0 scaled 2^13, a1 scaled 2^12, negated
// - software derives notch a0 from bandwidth
// - lowpass: mode 1, a0 zero, a1 computed
// - 8-bit volume code, zero mutes
// - volume resets to all ones, 0 dB
// - software commits only after both coefficient writes
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module anv_device
    import anv_pkg::*;
#(
    parameter int DEPTH = anv_pkg::FIFO_DEPTH
) (
    input  wire logic                          clk_in,
    input  wire logic                          rst_n_in,
    anv_reg_if.dev                             bus,
    input  wire logic                          in_valid_in,
    input  wire logic [anv_pkg::SAMPLE_W-1:0]  in_sample_in,
    output logic                               in_ready_out,
    output logic                               out_valid_out,
    output logic [anv_pkg::SAMPLE_W-1:0]       out_sample_out,
    input  wire logic                          out_ready_in
);
    import anv_pkg::*;

    // register state
    logic [7:0]          vol_reg, vol_next;
    logic                on_reg, on_next;
    logic [COEF_W-1:0]   a0_sh_reg, a0_sh_next;
    logic [COEF_W-1:0]   a1_sh_reg, a1_sh_next;
    logic                lp_sh_reg, lp_sh_next;
    logic [COEF_W-1:0]   a0_act_reg, a0_act_next;
    logic [COEF_W-1:0]   a1_act_reg, a1_act_next;
    logic                lp_act_reg, lp_act_next;
    logic                pend_reg, pend_next;
    logic [REG_DW-1:0]   rdata_reg, rdata_next;

    always_comb begin
        vol_next   = vol_reg;
        on_next    = on_reg;
        a0_sh_next = a0_sh_reg;
        a1_sh_next = a1_sh_reg;
        lp_sh_next = lp_sh_reg;
        pend_next  = 1'b0;
        rdata_next = DATA_ZERO;
        if (bus.wr) begin
            unique case (bus.addr)
                OFS_VOLUME: vol_next = bus.wdata[7:0];
                OFS_COEF_A: begin
                    on_next    = bus.wdata[BIT_ON];
                    a0_sh_next = bus.wdata[COEF_W-1:0];
                    pend_next  = bus.wdata[BIT_COMMIT];
                end
                OFS_COEF_B: begin
                    lp_sh_next = bus.wdata[BIT_LP];
                    a1_sh_next = bus.wdata[COEF_W-1:0];
                    pend_next  = bus.wdata[BIT_COMMIT];
                end
                default: ;
            endcase
        end
        if (bus.rd) begin
            unique case (bus.addr)
                OFS_VOLUME: rdata_next = {8'h00, vol_reg};
                OFS_COEF_A: rdata_next = {1'b0, on_reg, a0_sh_reg};
                OFS_COEF_B: rdata_next = {1'b0, lp_sh_reg, a1_sh_reg};
                default:    rdata_next = DATA_ZERO;
            endcase
        end
        // active set changes only after a commit write
        // both words and mode move on the same edge
        a0_act_next = pend_reg ? a0_sh_reg : a0_act_reg;
        a1_act_next = pend_reg ? a1_sh_reg : a1_act_reg;
        lp_act_next = pend_reg ? lp_sh_reg : lp_act_reg;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vol_reg    <= VOLUME_RESET;
            on_reg     <= 1'b0;
            a0_sh_reg  <= COEF_RESET;
            a1_sh_reg  <= COEF_RESET;
            lp_sh_reg  <= 1'b0;
            a0_act_reg <= COEF_RESET;
            a1_act_reg <= COEF_RESET;
            lp_act_reg <= 1'b0;
            pend_reg   <= 1'b0;
            rdata_reg  <= DATA_ZERO;
        end else begin
            vol_reg    <= vol_next;
            on_reg     <= on_next;
            a0_sh_reg  <= a0_sh_next;
            a1_sh_reg  <= a1_sh_next;
            lp_sh_reg  <= lp_sh_next;
            a0_act_reg <= a0_act_next;
            a1_act_reg <= a1_act_next;
            lp_act_reg <= lp_act_next;
            pend_reg   <= pend_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign bus.rdata = rdata_reg;

    // filter and volume datapath
    logic signed [STATE_W-1:0] w1_reg, w1_next;
    logic signed [STATE_W-1:0] w2_reg, w2_next;
    logic signed [17:0]        c0, c1, k0, k1, b1;
    logic signed [STATE_W-1:0] x, w, acc;
    logic signed [47:0]        p0, p1, p2, py;
    logic signed [SAMPLE_W-1:0] y16, vol16;
    logic [7:0]                step, halves;
    logic [3:0]                fidx;
    logic signed [32:0]        vprod;
    logic                      fifo_ready;
    logic                      accept;

    always_comb begin
        // stored field is the negated scaled coefficient
        c0 = -anv_sm_decode(a0_act_reg);
        c1 = -anv_sm_decode(a1_act_reg);
        k0 = (ONE_Q13 + c0) >>> 1;
        k1 = (ONE_Q12 + c1) >>> 1;
        p0 = c1 * (ONE_Q13 + c0);
        b1 = p0[A0_FRAC +: 18];
        x  = STATE_W'(in_sample_in);
        x  = $signed({{(STATE_W-SAMPLE_W){in_sample_in[SAMPLE_W-1]}},
                      in_sample_in});
        w  = x;
        acc = x;
        p1 = '0;
        p2 = '0;
        py = '0;
        if (lp_act_reg) begin
            p1  = c1 * w1_reg;
            w   = x - p1[A1_FRAC +: STATE_W];
            acc = w + w1_reg;
            py  = k1 * acc;
            acc = py[A1_FRAC +: STATE_W];
        end else begin
            p1  = b1 * w1_reg;
            p2  = c0 * w2_reg;
            w   = x - p1[A1_FRAC +: STATE_W] - p2[A0_FRAC +: STATE_W];
            p1  = (c1 <<< 1) * w1_reg;
            acc = w + p1[A1_FRAC +: STATE_W] + w2_reg;
            py  = k0 * acc;
            acc = py[A0_FRAC +: STATE_W];
        end
        if (!on_reg) begin
            acc = x;
        end
        if (acc > STATE_W'(32767)) begin
            y16 = 16'sh7fff;
        end else if (acc < -STATE_W'(32768)) begin
            y16 = -16'sh8000;
        end else begin
            y16 = acc[SAMPLE_W-1:0];
        end
        // 0.5 dB per code below all-ones
        step   = VOL_TOP - vol_reg;
        halves = step / VOL_PER_HALF;
        fidx   = 4'(step % VOL_PER_HALF);
        vprod  = y16 * $signed({1'b0, VOL_FRAC[fidx]});
        vprod  = vprod >>> (VOL_FRAC_W + 33'(halves));
        vol16  = (vol_reg == VOL_MUTE) ? '0 : vprod[SAMPLE_W-1:0];
        accept = in_valid_in && fifo_ready;
        w1_next = w1_reg;
        w2_next = w2_reg;
        if (!on_reg) begin
            w1_next = '0;
            w2_next = '0;
        end else if (accept) begin
            w1_next = w;
            w2_next = w1_reg;
        end
    end

    // output stage keeps the sample port on flip-flops
    logic                    fifo_valid;
    logic [SAMPLE_W-1:0]     fifo_data;
    logic                    pop;
    logic                    out_valid_reg, out_valid_next;
    logic [SAMPLE_W-1:0]     out_sample_reg, out_sample_next;

    anv_fifo #(.WIDTH(SAMPLE_W), .DEPTH(DEPTH)) u_fifo (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .s_valid_in  (in_valid_in),
        .s_data_in   (vol16),
        .s_ready_out (fifo_ready),
        .m_valid_out (fifo_valid),
        .m_data_out  (fifo_data),
        .m_ready_in  (pop)
    );

    always_comb begin
        pop = !out_valid_reg || out_ready_in;
        out_valid_next  = out_valid_reg && !out_ready_in;
        out_sample_next = out_sample_reg;
        if (pop && fifo_valid) begin
            out_valid_next  = 1'b1;
            out_sample_next = fifo_data;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            w1_reg         <= '0;
            w2_reg         <= '0;
            out_valid_reg  <= 1'b0;
            out_sample_reg <= '0;
        end else begin
            w1_reg         <= w1_next;
            w2_reg         <= w2_next;
            out_valid_reg  <= out_valid_next;
            out_sample_reg <= out_sample_next;
        end
    end

    assign in_ready_out   = fifo_ready;
    assign out_valid_out  = out_valid_reg;
    assign out_sample_out = out_sample_reg;
endmodule
`default_nettype wire

// [logic/anv_pkg.sv]
`default_nettype none
package anv_pkg;
    localparam int REG_AW   = 8;
    localparam int REG_DW   = 16;
    localparam int SAMPLE_W = 16;
    localparam int COEF_W   = 14;
    localparam int STATE_W  = 24;
    localparam int FIFO_DEPTH = 16;

    // device register offsets
    localparam logic [7:0] OFS_VOLUME = 8'h0f;
    localparam logic [7:0] OFS_COEF_A = 8'h16;
    localparam logic [7:0] OFS_COEF_B = 8'h17;

    // field positions
    localparam int BIT_COMMIT = 15;
    localparam int BIT_ON     = 14;
    localparam int BIT_LP     = 14;
    localparam int BIT_SIGN   = 13;

    // reset values
    localparam logic [7:0]  VOLUME_RESET = 8'hff;
    localparam logic [13:0] COEF_RESET   = 14'h0000;
    localparam logic [15:0] DATA_ZERO    = 16'h0000;

    // coefficient scaling: a0 has 13 fraction bits, a1 has 12
    localparam int A0_FRAC = 13;
    localparam int A1_FRAC = 12;
    localparam logic signed [17:0] ONE_Q13 = 18'sh02000;
    localparam logic signed [17:0] ONE_Q12 = 18'sh01000;

    // volume: code 0 mutes, 0.5 dB per code, 12 codes per halving
    localparam logic [7:0] VOL_MUTE     = 8'h00;
    localparam logic [7:0] VOL_TOP      = 8'hff;
    localparam logic [7:0] VOL_PER_HALF = 8'h0c;
    localparam int         VOL_FRAC_W   = 15;
    localparam logic [15:0] VOL_FRAC [12] = '{
        16'h8000, 16'h78d7, 16'h7215, 16'h6bb3, 16'h65ad, 16'h5ffd,
        16'h5a9e, 16'h558c, 16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4};

    // controller command offsets
    localparam int CMD_AW = 4;
    localparam logic [3:0] CMD_VOLUME  = 4'h0;
    localparam logic [3:0] CMD_A0      = 4'h1;
    localparam logic [3:0] CMD_A1      = 4'h2;
    localparam logic [3:0] CMD_MODE    = 4'h3;
    localparam logic [3:0] CMD_GO      = 4'h4;
    localparam logic [3:0] CMD_RD_ADDR = 4'h5;
    localparam logic [3:0] CMD_RD_DATA = 4'h6;
    localparam logic [3:0] CMD_STATUS  = 4'h7;
    localparam int MODE_ON_BIT = 0;
    localparam int MODE_LP_BIT = 1;

    typedef enum logic [2:0] {
        ANV_HS_IDLE    = 3'b000,
        ANV_HS_WR_A    = 3'b001,
        ANV_HS_WR_B    = 3'b010,
        ANV_HS_WR_VOL  = 3'b011,
        ANV_HS_RD_REQ  = 3'b100,
        ANV_HS_RD_WAIT = 3'b101
    } anv_host_state_t;

    // sign/magnitude word to two's complement
    function automatic logic signed [17:0] anv_sm_decode(
        input logic [13:0] v);
        logic signed [17:0] mag;
        mag = $signed({5'h00, v[12:0]});
        return v[BIT_SIGN] ? -mag : mag;
    endfunction

    // two's complement to sign/magnitude, -8192 clipped to -8191
    function automatic logic [13:0] anv_sm_encode(input logic [13:0] v);
        logic [13:0] neg;
        neg = -v;
        if (!v[BIT_SIGN])
            return v;
        if (v == 14'h2000)
            return 14'h3fff;
        return {1'b1, neg[12:0]};
    endfunction
endpackage
`default_nettype wire

// [logic/anv_reg_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface anv_reg_if;
    import anv_pkg::*;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;

    modport dev (input addr, input wdata, input wr, input rd,
                 output rdata);
    modport ctl (output addr, output wdata, output wr, output rd,
                 input rdata);
endinterface
`default_nettype wire

// [logic/anv_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module anv_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             s_valid_in,
    input  wire logic [WIDTH-1:0] s_data_in,
    output logic                  s_ready_out,
    output logic                  m_valid_out,
    output logic [WIDTH-1:0]      m_data_out,
    input  wire logic             m_ready_in
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0]    count_reg, count_next;
    logic             not_full_reg, not_full_next;
    logic             not_empty_reg, not_empty_next;
    logic             push;
    logic             pop;

    always_comb begin
        push = s_valid_in && not_full_reg;
        pop  = m_ready_in && not_empty_reg;
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = s_data_in;
            wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
        not_full_next  = (count_next != FULL_CNT);
        not_empty_next = (count_next != '0);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            not_full_reg  <= 1'b1;
            not_empty_reg <= 1'b0;
        end else begin
            mem_reg       <= mem_next;
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            count_reg     <= count_next;
            not_full_reg  <= not_full_next;
            not_empty_reg <= not_empty_next;
        end
    end

    assign s_ready_out = not_full_reg;
    assign m_valid_out = not_empty_reg;
    assign m_data_out  = mem_reg[rd_ptr_reg];
endmodule
`default_nettype wire

// [logic/anv_host.sv]
`timescale 1ns/10ps
`default_nettype none
module anv_host
    import anv_pkg::*;
(
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    anv_reg_if.ctl                           bus,
    input  wire logic [anv_pkg::CMD_AW-1:0]  cmd_addr_in,
    input  wire logic [anv_pkg::REG_DW-1:0]  cmd_wdata_in,
    input  wire logic                        cmd_wr_in,
    input  wire logic                        cmd_rd_in,
    output logic [anv_pkg::REG_DW-1:0]       cmd_rdata_out
);
    import anv_pkg::*;

    anv_host_state_t   state_reg, state_next;
    logic [7:0]        vol_reg, vol_next;
    logic [COEF_W-1:0] a0_reg, a0_next;
    logic [COEF_W-1:0] a1_reg, a1_next;
    logic              on_reg, on_next;
    logic              lp_reg, lp_next;
    logic [7:0]        rd_addr_reg, rd_addr_next;
    logic [REG_DW-1:0] rd_data_reg, rd_data_next;
    logic [REG_DW-1:0] cmd_rdata_reg, cmd_rdata_next;
    logic [7:0]        b_addr_reg, b_addr_next;
    logic [REG_DW-1:0] b_wdata_reg, b_wdata_next;
    logic              b_wr_reg, b_wr_next;
    logic              b_rd_reg, b_rd_next;
    logic              idle;
    logic [COEF_W-1:0] a0_word;

    always_comb begin
        idle = (state_reg == ANV_HS_IDLE);
        a0_word = lp_reg ? COEF_RESET : a0_reg;
        state_next     = state_reg;
        vol_next       = vol_reg;
        a0_next        = a0_reg;
        a1_next        = a1_reg;
        on_next        = on_reg;
        lp_next        = lp_reg;
        rd_addr_next   = rd_addr_reg;
        rd_data_next   = rd_data_reg;
        cmd_rdata_next = DATA_ZERO;
        b_addr_next    = b_addr_reg;
        b_wdata_next   = b_wdata_reg;
        b_wr_next      = 1'b0;
        b_rd_next      = 1'b0;
        if (cmd_wr_in) begin
            unique case (cmd_addr_in)
                CMD_VOLUME: vol_next = cmd_wdata_in[7:0];
                CMD_A0:     a0_next  = cmd_wdata_in[COEF_W-1:0];
                CMD_A1:     a1_next  = cmd_wdata_in[COEF_W-1:0];
                CMD_MODE: begin
                    on_next = cmd_wdata_in[MODE_ON_BIT];
                    lp_next = cmd_wdata_in[MODE_LP_BIT];
                end
                CMD_RD_ADDR: rd_addr_next = cmd_wdata_in[7:0];
                default: ;
            endcase
        end
        if (cmd_rd_in) begin
            unique case (cmd_addr_in)
                CMD_VOLUME:  cmd_rdata_next = {8'h00, vol_reg};
                CMD_A0:      cmd_rdata_next = {2'b00, a0_reg};
                CMD_A1:      cmd_rdata_next = {2'b00, a1_reg};
                CMD_MODE:    cmd_rdata_next = {14'h0000, lp_reg, on_reg};
                CMD_RD_ADDR: cmd_rdata_next = {8'h00, rd_addr_reg};
                CMD_RD_DATA: cmd_rdata_next = rd_data_reg;
                CMD_STATUS:  cmd_rdata_next = {15'h0000, !idle};
                default:     cmd_rdata_next = DATA_ZERO;
            endcase
        end
        unique case (state_reg)
            ANV_HS_IDLE: begin
                if (cmd_wr_in && cmd_addr_in == CMD_GO) begin
                    // encode a0 as sign/magnitude, no commit yet
                    state_next   = ANV_HS_WR_A;
                    b_addr_next  = OFS_COEF_A;
                    b_wdata_next = {1'b0, on_reg, anv_sm_encode(a0_word)};
                    b_wr_next    = 1'b1;
                end else if (cmd_wr_in && cmd_addr_in == CMD_RD_ADDR) begin
                    state_next  = ANV_HS_RD_REQ;
                    b_addr_next = cmd_wdata_in[7:0];
                    b_rd_next   = 1'b1;
                end
            end
            ANV_HS_WR_A: begin
                // commit rides on the second coefficient write
                state_next   = ANV_HS_WR_B;
                b_addr_next  = OFS_COEF_B;
                b_wdata_next = {1'b1, lp_reg, anv_sm_encode(a1_reg)};
                b_wr_next    = 1'b1;
            end
            ANV_HS_WR_B: begin
                state_next   = ANV_HS_WR_VOL;
                b_addr_next  = OFS_VOLUME;
                b_wdata_next = {8'h00, vol_reg};
                b_wr_next    = 1'b1;
            end
            ANV_HS_WR_VOL: state_next = ANV_HS_IDLE;
            ANV_HS_RD_REQ: state_next = ANV_HS_RD_WAIT;
            ANV_HS_RD_WAIT: begin
                rd_data_next = bus.rdata;
                state_next   = ANV_HS_IDLE;
            end
            default: state_next = ANV_HS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg     <= ANV_HS_IDLE;
            vol_reg       <= VOLUME_RESET;
            a0_reg        <= COEF_RESET;
            a1_reg        <= COEF_RESET;
            on_reg        <= 1'b0;
            lp_reg        <= 1'b0;
            rd_addr_reg   <= 8'h00;
            rd_data_reg   <= DATA_ZERO;
            cmd_rdata_reg <= DATA_ZERO;
            b_addr_reg    <= 8'h00;
            b_wdata_reg   <= DATA_ZERO;
            b_wr_reg      <= 1'b0;
            b_rd_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            vol_reg       <= vol_next;
            a0_reg        <= a0_next;
            a1_reg        <= a1_next;
            on_reg        <= on_next;
            lp_reg        <= lp_next;
            rd_addr_reg   <= rd_addr_next;
            rd_data_reg   <= rd_data_next;
            cmd_rdata_reg <= cmd_rdata_next;
            b_addr_reg    <= b_addr_next;
            b_wdata_reg   <= b_wdata_next;
            b_wr_reg      <= b_wr_next;
            b_rd_reg      <= b_rd_next;
        end
    end

    assign bus.addr      = b_addr_reg;
    assign bus.wdata     = b_wdata_reg;
    assign bus.wr        = b_wr_reg;
    assign bus.rd        = b_rd_reg;
    assign cmd_rdata_out = cmd_rdata_reg;
endmodule
`default_nettype wire

// [verification/anv_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module anv_assertions
    import anv_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_in
);
    import anv_pkg::*;
    wire logic is_a = wr_in && addr_in == OFS_COEF_A;
    wire logic is_b = wr_in && addr_in == OFS_COEF_B;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_commit_reads_zero: assert property (
        rd_in |=> !rdata_in[BIT_COMMIT])
        else $error("commit bit read back high");
    a_volume_field_only: assert property (
        rd_in && addr_in == OFS_VOLUME |=> rdata_in[15:8] == 8'h00)
        else $error("volume read has upper bits set");
    a_first_write_open: assert property (
        is_a |-> !wdata_in[BIT_COMMIT])
        else $error("commit on first coef write");
    a_second_write_commits: assert property (
        is_b |-> wdata_in[BIT_COMMIT])
        else $error("second coef write lacks commit");
    a_coef_pair_order: assert property (
        is_a |=> is_b) else $error("coef writes not back to back");
    a_lowpass_a0_zero: assert property (
        is_a ##1 (is_b && wdata_in[BIT_LP]) |->
            $past(wdata_in[13:0]) == 14'h0000)
        else $error("lowpass mode with nonzero a0");
    a_no_minus_zero: assert property (
        is_a || is_b |-> wdata_in[13:0] != 14'h2000)
        else $error("coef written as minus zero");
    a_volume_follows: assert property (
        is_b |=> wr_in && addr_in == OFS_VOLUME && wdata_in[15:8] == 8'h00)
        else $error("volume write missing after coefs");

    c_lowpass_commit: cover property (is_b && wdata_in[BIT_LP]);
    c_nonzero_read: cover property (rd_in ##1 rdata_in != 16'h0000);
    c_mute_write: cover property (
        wr_in && addr_in == OFS_VOLUME && wdata_in == 16'h0);
endmodule
`default_nettype wire

// [verification/adc_notch3_and_volume_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module adc_notch3_and_volume_bench;
    import anv_pkg::*;
    logic        clk_in, rst_n_in = 0, cmd_wr = 0, cmd_rd = 0, ok;
    logic        in_valid = 0, in_ready, out_valid, out_ready = 0;
    logic [3:0]  cmd_addr = 0;
    logic [15:0] cmd_wdata = 0, cmd_rdata, in_sample = 0, out_sample;
    logic [7:0]  vols [3] = '{8'h00, 8'hf3, 8'he7};
    logic [15:0] exps [3] = '{16'h0000, 16'h0800, 16'h0400};
    int          n_fail = 0, comparisons = 0, i, k;

    anv_reg_if anv_reg_if_inst();
    anv_device anv_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .bus(anv_reg_if_inst), .in_valid_in(in_valid),
        .in_sample_in(in_sample), .in_ready_out(in_ready),
        .out_valid_out(out_valid), .out_sample_out(out_sample),
        .out_ready_in(out_ready));
    anv_host anv_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .bus(anv_reg_if_inst), .cmd_addr_in(cmd_addr),
        .cmd_wdata_in(cmd_wdata), .cmd_wr_in(cmd_wr), .cmd_rd_in(cmd_rd),
        .cmd_rdata_out(cmd_rdata));
    anv_assertions anv_assertions_inst (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .addr_in(anv_reg_if_inst.addr),
        .wdata_in(anv_reg_if_inst.wdata), .wr_in(anv_reg_if_inst.wr),
        .rd_in(anv_reg_if_inst.rd), .rdata_in(anv_reg_if_inst.rdata));

    initial begin
        clk_in = 0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic finish_test;
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic timeout;
        n_fail++;
        finish_test();
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic host_wr(input logic [3:0] a, input logic [15:0] d);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk_in);
        cmd_wr <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic host_rd(input logic [3:0] a, output logic [15:0] d);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clk_in);
        cmd_rd <= 1'b0;
        @(negedge clk_in);
        d = cmd_rdata;
        @(posedge clk_in);
    endtask
    task automatic wait_idle;
        logic [15:0] v;
        int n;
        v = 16'h0001;
        n = 0;
        while (v[0] !== 1'b0) begin
            if (n++ > 20) timeout();
            host_rd(4'h7, v);
        end
    endtask
    task automatic dev_rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        host_wr(4'h5, {8'h00, a});
        wait_idle();
        host_rd(4'h6, v);
        check(v, e);
    endtask
    task automatic setup(input logic [7:0] vol, input logic [15:0] a0,
                         input logic [15:0] a1, input logic [15:0] md);
        host_wr(4'h0, {8'h00, vol});
        host_wr(4'h1, a0);
        host_wr(4'h2, a1);
        host_wr(4'h3, md);
        host_wr(4'h4, 16'h0000);
        wait_idle();
    endtask
    task automatic send(input logic [15:0] s, output logic taken);
        in_valid <= 1'b1;
        in_sample <= s;
        @(negedge clk_in);
        taken = in_ready;
        @(posedge clk_in);
        in_valid <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic recv(input logic [15:0] e);
        int n;
        n = 0;
        out_ready <= 1'b1;
        @(negedge clk_in);
        while (out_valid !== 1'b1) begin
            if (n++ > 40) timeout();
            @(negedge clk_in);
        end
        check(out_sample, e);
        @(posedge clk_in);
        out_ready <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic xfer(input logic [15:0] s, input logic [15:0] e);
        send(s, ok);
        recv(e);
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        dev_rd(8'h0f, 16'h00ff);
        dev_rd(8'h16, 16'h0000);
        dev_rd(8'h17, 16'h0000);
        dev_rd(8'h20, 16'h0000);
        xfer(16'h1234, 16'h1234);
        for (i = 0; i < 3; i++) begin
            setup(vols[i], 16'h0000, 16'h0000, 16'h0000);
            xfer(16'h1000, exps[i]);
        end
        setup(8'hff, 16'h3f9c, 16'h0032, 16'h0001);
        dev_rd(8'h16, 16'h6064);
        dev_rd(8'h17, 16'h0032);
        setup(8'hff, 16'h0005, 16'h3ff8, 16'h0002);
        dev_rd(8'h16, 16'h0000);
        dev_rd(8'h17, 16'h6008);
        xfer(16'hfedc, 16'hfedc);
        k = 0;
        ok = 1'b1;
        while (ok && k < 40) begin
            send(16'h0100 + k[15:0], ok);
            if (ok) k++;
        end
        // fifo words plus the output flop
        check(k[15:0], 16'(FIFO_DEPTH + 1));
        for (i = 0; i < k; i++)
            recv(16'h0100 + i[15:0]);
        // zero coefs: notch (x[n]+x[n-2])/2, lowpass (x[n]+x[n-1])/2
        setup(8'hff, 16'h0000, 16'h0000, 16'h0001);
        xfer(16'h1000, 16'h0800);
        xfer(16'h0000, 16'h0000);
        xfer(16'h0000, 16'h0800);
        setup(8'hff, 16'h0000, 16'h0000, 16'h0003);
        xfer(16'h1000, 16'h0800);
        xfer(16'h1000, 16'h1000);
        finish_test();
    end
endmodule
`default_nettype wire
